// ### acs_afe_model.sv
// behavioural analog front end answering convert strobes
`timescale 1ns/10ps
`default_nettype none
module acs_afe_model
    import acs_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // strobe and test controls
    input wire logic convert_i,
    input wire logic [7:0] delay_i,
    input wire logic [11:0] raw_i,
    // result towards the sequencer
    output var acs_afe_result_type result_o
);
    logic [8:0] cnt_q;
    logic [11:0] last_q;

    // data outside the done pulse is not held: inverse of last result
    always_ff @(posedge clock_i)
    begin
        result_o.done <= 1'b0;
        result_o.data <= ~last_q;
        if (rst_i)
        begin
            cnt_q <= 9'h0;
            last_q <= 12'h0;
        end
        else if (convert_i)
            cnt_q <= {1'b0, delay_i} + 9'h1;
        else if (cnt_q == 9'h1)
        begin
            cnt_q <= 9'h0;
            last_q <= raw_i;
            result_o.done <= 1'b1;
            result_o.data <= raw_i;
        end
        else if (cnt_q != 9'h0)
            cnt_q <= cnt_q - 9'h1;
    end
endmodule // acs_afe_model
`default_nettype wire

// ### acs_format.sv
// result formatting into a 16-bit word
`timescale 1ns/10ps
`default_nettype none
module acs_format
    import acs_pkg::*;
(
    // raw result and mode
    input wire logic [11:0] raw_i,
    input wire logic resolution_select_i,
    input wire logic [1:0] output_format_i,
    // formatted word
    output logic [15:0] word_o
);

    logic sign_10;
    logic sign_12;

    assign sign_10 = ~raw_i[9];
    assign sign_12 = ~raw_i[11];

    always_comb
    begin
        if (resolution_select_i)
        begin
            if (output_format_i == FORM_SIGNED)
                word_o = {{5{sign_12}}, raw_i[10:0]}; // R7
            else
                word_o = {4'h0, raw_i}; // R7
        end
        else
        begin
            if (output_format_i == FORM_SIGNED)
                word_o = {{7{sign_10}}, raw_i[8:0]}; // R6
            else
                word_o = {6'h00, raw_i[9:0]}; // R6
        end
    end

endmodule // acs_format
`default_nettype wire

// ### acs_pkg.sv
// constants, register map and carrier types of the converter sequencer
package acs_pkg;

    // clock and timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int AUTO_SAMPLE_NS = 400;
    localparam int AUTO_SAMPLE_CYCLES =
        (AUTO_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SAMPLE_CNT_W = 8;

    // sizes
    localparam int NUM_PINS = 16;
    localparam int DMA_ADDR_W = 8;
    localparam int BUF_IDX_W = 4;
    localparam int SET_CNT_W = 8;
    localparam int REG_ADDR_W = 4;

    // register word addresses
    localparam logic [3:0] ADDR_CONTROL_ONE = 4'h0;
    localparam logic [3:0] ADDR_MODULE_DISABLE = 4'h1;
    localparam logic [3:0] ADDR_PIN_CONFIG = 4'h2;
    localparam logic [3:0] ADDR_DMA_CONFIG = 4'h3;
    localparam logic [3:0] ADDR_RESULT = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h5;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;
    localparam logic [3:0] ADDR_PORT_VALUE = 4'h7;

    // control_one and module disable field positions
    localparam int POS_MODULE_POWER = 15;
    localparam int POS_IDLE_STOP = 13;
    localparam int POS_DMA_BUILD_ORDER = 12;
    localparam int POS_RESOLUTION_SELECT = 10;
    localparam int POS_OUTPUT_FORMAT = 8;
    localparam int POS_TRIGGER_SOURCE = 5;
    localparam int POS_SIMULTANEOUS = 3;
    localparam int POS_AUTO_SAMPLE = 2;
    localparam int POS_SAMPLE_ACTIVE = 1;
    localparam int POS_CONV_DONE = 0;
    localparam int POS_CONVERTER2_DISABLE = 0;

    // irq status bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_MISSED = 1;
    localparam int IRQ_W = 2;

    // reset values
    localparam logic [15:0] RESET_PIN_CONFIG = 16'h0000;
    localparam logic [2:0] RESET_DMA_SIZE = 3'h0;

    // trigger source codes
    localparam logic [2:0] TRIG_SOFTWARE = 3'h0;
    localparam logic [2:0] TRIG_EXT_PIN = 3'h1;
    localparam logic [2:0] TRIG_TIMER_A = 3'h2;
    localparam logic [2:0] TRIG_TIMER_B = 3'h4;
    localparam logic [2:0] TRIG_AUTO = 3'h7;

    // output format codes
    localparam logic [1:0] FORM_INTEGER = 2'h0;
    localparam logic [1:0] FORM_SIGNED = 2'h1;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_CONVERT
    } acs_fsm_type;

    typedef struct packed {
        logic module_power;
        logic idle_stop;
        logic dma_build_order;
        logic resolution_select;
        logic [1:0] output_format;
        logic [2:0] trigger_source;
        logic simultaneous_sampling;
        logic auto_sample;
        logic sample_active;
        logic conv_done;
    } acs_ctrl_type;

    typedef struct packed {
        logic [REG_ADDR_W-1:0] addr;
        logic [15:0] wdata;
        logic write;
        logic read;
    } acs_bus_req_type;

    typedef struct packed {
        logic done;
        logic [11:0] data;
    } acs_afe_result_type;

    typedef struct packed {
        logic req;
        logic [DMA_ADDR_W-1:0] addr;
        logic [15:0] data;
    } acs_dma_type;

endpackage : acs_pkg

// ### acs_top.sv
// converter control sequencer: registers, sampling, triggers, dma addressing
// Functional notes
// R1 - converter runs only while module_power is one
// R2 - idle_stop at one halts the converter during idle mode
// R3 - build order one: dma address equals the standalone buffer address
// R4 - build order zero: address from input index and dma buffer size
// R5 - resolution_select one gives 12-bit single channel, zero 10-bit four
// R6 - 10-bit: format 00 zero-extends, 01 fills with inverted bit 9
// R7 - 12-bit: format 00 zero-extends, 01 fills with inverted bit 11
// R8 - trigger 111: internal counter ends sampling, starts conversion
// R9 - trigger 100: timer 5 match (timer 3 on second converter)
// R10 - trigger 010: timer 3 match (timer 5 on second converter)
// R11 - trigger 001: active edge of external irq pin zero
// R12 - trigger 000: clearing sample_active ends sampling; 110 and 011 reserved
// R13 - hardware sets and clears sample_active and conv_done
// R14 - bits 14, 11, 4 read zero; all control bits reset to zero
// R15 - converter2_disable one disables the second converter
// R16 - disabled converter forces all shared pins to digital mode
// R17 - analog-configured pin reads zero on a digital port read
// R18 - conv_done set on result write, held until software or new sample; a new sample started by auto_sample leaves it set
`timescale 1ns/10ps
`default_nettype none
module acs_top
    import acs_pkg::*;
#(
    parameter bit SECOND_CONVERTER = 1'b0
)
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // register port
    input wire acs_bus_req_type bus_i,
    output logic [15:0] rdata_o,
    // system
    input wire logic idle_mode_i,
    input wire logic timer3_match_i,
    input wire logic timer5_match_i,
    input wire logic external_irq_pin_zero_i,
    // analog front end
    input wire acs_afe_result_type afe_i,
    output logic afe_sample_o,
    output logic afe_convert_o,
    output logic [1:0] afe_channel_o,
    output logic afe_twelve_bit_o,
    // dma channel
    output acs_dma_type dma_o,
    // port pins
    input wire logic [NUM_PINS-1:0] port_pins_i,
    output logic [NUM_PINS-1:0] pin_digital_o,
    output logic [NUM_PINS-1:0] port_read_o,
    // interrupt
    output logic irq_o
);

    typedef struct packed {
        acs_ctrl_type ctrl;
        logic converter2_disable;
        logic [NUM_PINS-1:0] pin_config;
        logic [2:0] dma_size_log2;
        logic [15:0] result;
        logic [IRQ_W-1:0] status;
        logic [IRQ_W-1:0] mask;
        acs_fsm_type fsm;
        logic [SAMPLE_CNT_W-1:0] sample_cnt;
        logic [1:0] chan;
        logic [SET_CNT_W-1:0] set_cnt;
        logic [BUF_IDX_W-1:0] buf_idx;
        logic ext_prev;
        logic [15:0] rdata;
        logic irq;
        logic sample;
        logic convert;
        acs_dma_type dma;
        logic [NUM_PINS-1:0] digital;
        logic [NUM_PINS-1:0] port_read;
    } acs_state_type;

    localparam logic [SAMPLE_CNT_W-1:0] AUTO_SAMPLE_LAST =
        SAMPLE_CNT_W'(AUTO_SAMPLE_CYCLES - 1);

    acs_state_type s_q;
    acs_state_type s_d;

    logic [15:0] formatted;
    logic [15:0] ctrl_word;
    logic [NUM_PINS-1:0] digital_next;
    logic [NUM_PINS-1:0] port_next;
    logic disabled;
    logic running;
    logic halted;
    logic ext_edge;
    logic timer_a;
    logic timer_b;
    logic hw_trigger;
    logic trigger;
    logic wr_ctrl;
    logic [1:0] last_chan;
    logic [DMA_ADDR_W-1:0] sg_mask;
    logic [DMA_ADDR_W-1:0] sg_addr;
    logic [DMA_ADDR_W-1:0] seq_addr;

    acs_format u_format (
        .raw_i(afe_i.data),
        .resolution_select_i(s_q.ctrl.resolution_select),
        .output_format_i(s_q.ctrl.output_format),
        .word_o(formatted)
    );

    // control word as read, unimplemented positions zero
    always_comb
    begin
        ctrl_word = 16'h0000; // R14
        ctrl_word[POS_MODULE_POWER] = s_q.ctrl.module_power;
        ctrl_word[POS_IDLE_STOP] = s_q.ctrl.idle_stop;
        ctrl_word[POS_DMA_BUILD_ORDER] = s_q.ctrl.dma_build_order;
        ctrl_word[POS_RESOLUTION_SELECT] = s_q.ctrl.resolution_select;
        ctrl_word[POS_OUTPUT_FORMAT +: 2] = s_q.ctrl.output_format;
        ctrl_word[POS_TRIGGER_SOURCE +: 3] = s_q.ctrl.trigger_source;
        ctrl_word[POS_SIMULTANEOUS] = s_q.ctrl.simultaneous_sampling;
        ctrl_word[POS_AUTO_SAMPLE] = s_q.ctrl.auto_sample;
        ctrl_word[POS_SAMPLE_ACTIVE] = s_q.ctrl.sample_active;
        ctrl_word[POS_CONV_DONE] = s_q.ctrl.conv_done;
    end

    assign disabled = SECOND_CONVERTER & s_q.converter2_disable; // R15
    assign running = s_q.ctrl.module_power & ~disabled; // R1
    assign halted = s_q.ctrl.idle_stop & idle_mode_i; // R2

    // timer roles swap on the second converter
    assign timer_b = SECOND_CONVERTER ? timer3_match_i
                                      : timer5_match_i; // R9
    assign timer_a = SECOND_CONVERTER ? timer5_match_i
                                      : timer3_match_i; // R10
    assign ext_edge = external_irq_pin_zero_i & ~s_q.ext_prev; // R11

    always_comb
    begin
        case (s_q.ctrl.trigger_source)
            TRIG_AUTO: hw_trigger = (s_q.sample_cnt == AUTO_SAMPLE_LAST); // R8
            TRIG_TIMER_B: hw_trigger = timer_b; // R9
            TRIG_TIMER_A: hw_trigger = timer_a; // R10
            TRIG_EXT_PIN: hw_trigger = ext_edge; // R11
            TRIG_SOFTWARE: hw_trigger = ~s_q.ctrl.sample_active; // R12
            default: hw_trigger = 1'b0; // R12
        endcase
    end

    assign trigger = hw_trigger & (s_q.fsm == ST_SAMPLE);
    assign wr_ctrl = bus_i.write & (bus_i.addr == ADDR_CONTROL_ONE);
    assign last_chan = s_q.ctrl.resolution_select ? 2'h0 : 2'h3; // R5

    // scatter/gather: input index selects a block of 2^size words
    assign sg_mask = DMA_ADDR_W'((9'h001 << s_q.dma_size_log2) - 9'h001);
    assign sg_addr = DMA_ADDR_W'({6'h00, s_q.chan} << s_q.dma_size_log2)
                   | (DMA_ADDR_W'(s_q.set_cnt) & sg_mask); // R4
    assign seq_addr = DMA_ADDR_W'(s_q.buf_idx); // R3

    // per-pin digital mode and port readback
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi = gi + 1)
        begin : g_pin
            assign digital_next[gi] = disabled
                                    | s_q.pin_config[gi]; // R16
            assign port_next[gi] = digital_next[gi]
                                 & port_pins_i[gi]; // R17
        end
    endgenerate

    always_comb
    begin
        s_d = s_q;
        s_d.convert = 1'b0;
        s_d.dma.req = 1'b0;
        s_d.ext_prev = external_irq_pin_zero_i;
        s_d.digital = digital_next;
        s_d.port_read = port_next;

        // register writes
        if (wr_ctrl)
        begin
            s_d.ctrl.module_power = bus_i.wdata[POS_MODULE_POWER];
            s_d.ctrl.idle_stop = bus_i.wdata[POS_IDLE_STOP];
            s_d.ctrl.dma_build_order = bus_i.wdata[POS_DMA_BUILD_ORDER];
            s_d.ctrl.resolution_select = bus_i.wdata[POS_RESOLUTION_SELECT];
            s_d.ctrl.output_format = bus_i.wdata[POS_OUTPUT_FORMAT +: 2];
            s_d.ctrl.trigger_source = bus_i.wdata[POS_TRIGGER_SOURCE +: 3];
            s_d.ctrl.simultaneous_sampling = bus_i.wdata[POS_SIMULTANEOUS];
            s_d.ctrl.auto_sample = bus_i.wdata[POS_AUTO_SAMPLE];
            s_d.ctrl.sample_active = bus_i.wdata[POS_SAMPLE_ACTIVE]; // R13
            // done is read/clear: software may only clear it
            if (!bus_i.wdata[POS_CONV_DONE])
                s_d.ctrl.conv_done = 1'b0; // R13
        end
        if (bus_i.write)
        begin
            case (bus_i.addr)
                ADDR_MODULE_DISABLE:
                    s_d.converter2_disable =
                        bus_i.wdata[POS_CONVERTER2_DISABLE]; // R15
                ADDR_PIN_CONFIG: s_d.pin_config = bus_i.wdata[NUM_PINS-1:0];
                ADDR_DMA_CONFIG: s_d.dma_size_log2 = bus_i.wdata[2:0];
                ADDR_IRQ_STATUS: s_d.status = s_q.status
                                            & ~bus_i.wdata[IRQ_W-1:0];
                ADDR_IRQ_MASK: s_d.mask = bus_i.wdata[IRQ_W-1:0];
                default: ;
            endcase
        end

        // sequencer
        if (!running)
        begin
            s_d.fsm = ST_IDLE; // R1
            s_d.sample = 1'b0;
            s_d.sample_cnt = '0;
            s_d.chan = 2'h0;
        end
        else if (!halted) // R2
        begin
            case (s_q.fsm)
                ST_IDLE:
                begin
                    if (s_q.ctrl.sample_active)
                    begin
                        s_d.fsm = ST_SAMPLE;
                        s_d.sample = 1'b1;
                        s_d.sample_cnt = '0;
                        s_d.ctrl.conv_done = 1'b0; // R18
                    end
                end
                ST_SAMPLE:
                begin
                    s_d.sample_cnt = s_q.sample_cnt + 1'b1;
                    if (trigger)
                    begin
                        s_d.fsm = ST_CONVERT;
                        s_d.sample = 1'b0;
                        s_d.convert = 1'b1;
                        s_d.ctrl.sample_active = 1'b0; // R13
                    end
                end
                ST_CONVERT:
                begin
                    if (hw_trigger
                        && s_q.ctrl.trigger_source != TRIG_SOFTWARE
                        && s_q.ctrl.trigger_source != TRIG_AUTO)
                        s_d.status[IRQ_MISSED] = 1'b1;
                    if (afe_i.done)
                    begin
                        s_d.result = formatted;
                        s_d.dma.req = 1'b1;
                        s_d.dma.data = formatted;
                        s_d.dma.addr = s_q.ctrl.dma_build_order
                                     ? seq_addr : sg_addr; // R3 R4
                        s_d.buf_idx = s_q.buf_idx + 1'b1;
                        s_d.ctrl.conv_done = 1'b1; // R18
                        s_d.status[IRQ_DONE] = 1'b1;
                        if (s_q.chan >= last_chan) // R5
                        begin
                            s_d.chan = 2'h0;
                            s_d.set_cnt = s_q.set_cnt + 1'b1;
                        end
                        else
                            s_d.chan = s_q.chan + 1'b1;
                        if (s_q.ctrl.auto_sample)
                        begin
                            s_d.fsm = ST_SAMPLE;
                            s_d.sample = 1'b1;
                            s_d.sample_cnt = '0;
                            s_d.ctrl.sample_active = 1'b1; // R13
                        end
                        else
                            s_d.fsm = ST_IDLE;
                    end
                end
                default: s_d.fsm = ST_IDLE;
            endcase
        end

        // register reads, data in the following cycle
        s_d.rdata = 16'h0000;
        if (bus_i.read)
        begin
            case (bus_i.addr)
                ADDR_CONTROL_ONE: s_d.rdata = ctrl_word; // R14
                ADDR_MODULE_DISABLE:
                    s_d.rdata[POS_CONVERTER2_DISABLE] = s_q.converter2_disable;
                ADDR_PIN_CONFIG: s_d.rdata = 16'(s_q.pin_config);
                ADDR_DMA_CONFIG: s_d.rdata = {13'h0000, s_q.dma_size_log2};
                ADDR_RESULT: s_d.rdata = s_q.result;
                ADDR_IRQ_STATUS: s_d.rdata = 16'(s_q.status);
                ADDR_IRQ_MASK: s_d.rdata = 16'(s_q.mask);
                ADDR_PORT_VALUE: s_d.rdata = 16'(s_q.port_read); // R17
                default: s_d.rdata = 16'h0000;
            endcase
        end

        s_d.irq = |(s_d.status & s_d.mask);
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            s_q <= '0; // R14
            s_q.pin_config <= RESET_PIN_CONFIG;
            s_q.dma_size_log2 <= RESET_DMA_SIZE;
            s_q.fsm <= ST_IDLE;
        end
        else
            s_q <= s_d;
    end

    assign rdata_o = s_q.rdata;
    assign afe_sample_o = s_q.sample;
    assign afe_convert_o = s_q.convert;
    assign afe_channel_o = s_q.chan;
    assign afe_twelve_bit_o = s_q.ctrl.resolution_select; // R5
    assign dma_o = s_q.dma;
    assign pin_digital_o = s_q.digital;
    assign port_read_o = s_q.port_read;
    assign irq_o = s_q.irq;

endmodule // acs_top
`default_nettype wire

// ### acs_top_sva.sv
// assertion checker for the converter sequencer ports
`timescale 1ns/10ps
`default_nettype none
module acs_top_sva
    import acs_pkg::*;
(
    // clock, reset and register port
    input wire logic clock_i,
    input wire logic rst_i,
    input wire acs_bus_req_type bus_i,
    input wire logic [15:0] rdata_o,
    // converter side
    input wire acs_afe_result_type afe_i,
    input wire logic afe_sample_o,
    input wire logic afe_convert_o,
    input wire logic [1:0] afe_channel_o,
    input wire logic afe_twelve_bit_o,
    input wire acs_dma_type dma_o,
    // pins
    input wire logic [NUM_PINS-1:0] port_pins_i,
    input wire logic [NUM_PINS-1:0] pin_digital_o,
    input wire logic [NUM_PINS-1:0] port_read_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    a_power_off: assert property (bus_i.write && !bus_i.wdata[15]
        && bus_i.addr == ADDR_CONTROL_ONE |-> ##2 !afe_sample_o)
        else $error("sampling kept running with power off");
    a_convert_pulse: assert property (afe_convert_o |=> !afe_convert_o)
        else $error("convert strobe longer than one cycle");
    a_dma_cause: assert property (dma_o.req |-> $past(afe_i.done))
        else $error("dma request without a finished conversion");
    a_dma_pulse: assert property (dma_o.req |=> !dma_o.req)
        else $error("dma request longer than one cycle");
    a_single_chan: assert property (afe_convert_o && afe_twelve_bit_o
        |-> afe_channel_o == 2'h0)
        else $error("12-bit mode converted a channel other than zero");
    a_mode_follow: assert property (bus_i.write
        && bus_i.addr == ADDR_CONTROL_ONE
        |-> ##2 afe_twelve_bit_o == $past(bus_i.wdata[10], 2))
        else $error("resolution output does not follow control word");
    a_unimpl_zero: assert property (bus_i.read
        && bus_i.addr == ADDR_CONTROL_ONE |=> (rdata_o & 16'h4810) == 16'h0)
        else $error("unimplemented control bits read nonzero");
    a_port_read: assert property (port_read_o ==
        ($past(port_pins_i) & pin_digital_o))
        else $error("analog pin read back nonzero");
endmodule // acs_top_sva

bind acs_top acs_top_sva chk_u (
    .clock_i,
    .rst_i,
    .bus_i,
    .rdata_o,
    .afe_i,
    .afe_sample_o,
    .afe_convert_o,
    .afe_channel_o,
    .afe_twelve_bit_o,
    .dma_o,
    .port_pins_i,
    .pin_digital_o,
    .port_read_o
);
`default_nettype wire

// ### acs_top_test.sv
// self-checking bench for the converter sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
    error_cnt++; \
    $display("BAD %0t got %h want %h", $time, (g), (e)); \
    end end
module acs_top_test
    import acs_pkg::*;
;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    acs_bus_req_type bus_i = '0;
    logic idle_mode_i = 1'b0;
    logic timer3_match_i = 1'b0;
    logic timer5_match_i = 1'b0;
    logic external_irq_pin_zero_i = 1'b0;
    logic [NUM_PINS-1:0] port_pins_i = 16'ha5c3;
    logic [7:0] delay = 8'h3;
    logic [11:0] raw = 12'h0;
    acs_afe_result_type afe_i;
    acs_dma_type dma_o;
    logic [15:0] rdata_o;
    logic afe_sample_o;
    logic afe_convert_o;
    logic [1:0] afe_channel_o;
    logic afe_twelve_bit_o;
    logic [NUM_PINS-1:0] pin_digital_o;
    logic [NUM_PINS-1:0] port_read_o;
    logic irq_o;
    logic [NUM_PINS-1:0] digital2;
    logic sample2;
    int error_cnt = 0;
    int tests_run = 0;
    int run = 0;
    int run_len = 0;

    always #12.5 clock_i = ~clock_i;

    acs_top dut_u (.clock_i, .rst_i, .bus_i, .rdata_o, .idle_mode_i,
        .timer3_match_i, .timer5_match_i, .external_irq_pin_zero_i, .afe_i,
        .afe_sample_o, .afe_convert_o, .afe_channel_o, .afe_twelve_bit_o,
        .dma_o, .port_pins_i, .pin_digital_o, .port_read_o, .irq_o);

    // second converter instance, kept disabled
    acs_top #(.SECOND_CONVERTER(1'b1)) dut2_u (.clock_i, .rst_i, .bus_i,
        .rdata_o(), .idle_mode_i, .timer3_match_i, .timer5_match_i,
        .external_irq_pin_zero_i, .afe_i, .afe_sample_o(sample2),
        .afe_convert_o(), .afe_channel_o(), .afe_twelve_bit_o(), .dma_o(),
        .port_pins_i, .pin_digital_o(digital2), .port_read_o(), .irq_o());

    acs_afe_model afe_u (.clock_i, .rst_i, .convert_i(afe_convert_o),
        .delay_i(delay), .raw_i(raw), .result_o(afe_i));

    // length of the sampling phase ahead of each convert strobe
    always @(posedge clock_i)
    begin
        if (afe_convert_o === 1'b1)
            run_len = run;
        run = (afe_sample_o === 1'b1) ? run + 1 : 0;
    end

    task automatic give_verdict();
        if (error_cnt == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        bus_i.addr <= a;
        bus_i.wdata <= d;
        bus_i.write <= 1'b1;
        @(posedge clock_i);
        bus_i.write <= 1'b0;
        @(posedge clock_i);
    endtask

    task automatic rchk(input logic [3:0] a, input logic [15:0] e);
        bus_i.addr <= a;
        bus_i.read <= 1'b1;
        @(posedge clock_i);
        bus_i.read <= 1'b0;
        #1;
        `CHK(rdata_o, e)
        @(posedge clock_i);
    endtask

    task automatic fire(input int k);
        case (k)
            1: external_irq_pin_zero_i <= 1'b1;
            2: timer3_match_i <= 1'b1;
            3: timer5_match_i <= 1'b1;
            default: ;
        endcase
        @(posedge clock_i);
        {external_irq_pin_zero_i, timer3_match_i, timer5_match_i} <= 3'h0;
        @(posedge clock_i);
    endtask

    task automatic wait_req(input int n, output bit got);
        got = 1'b0;
        for (int i = 0; i < n && !got; i++)
        begin
            @(posedge clock_i);
            #1;
            got = (dma_o.req === 1'b1);
        end
        @(posedge clock_i);
    endtask

    function automatic logic [15:0] fmt(logic [11:0] r, logic res, logic f);
        if (res)
            return f ? {{5{~r[11]}}, r[10:0]} : {4'h0, r};
        return f ? {{7{~r[9]}}, r[8:0]} : {6'h0, r[9:0]};
    endfunction

    initial
    begin
        int trig[5] = '{7, 0, 1, 2, 4};
        int good[5] = '{0, 4, 1, 2, 3};
        int bad[5] = '{0, 3, 2, 3, 2};
        logic [15:0] w;
        logic [15:0] c;
        bit got;
        void'($urandom(3));
        repeat (6) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        for (int a = 0; a < 16; a++)
            rchk(4'(a), 16'h0);
        wr(ADDR_MODULE_DISABLE, 16'h0001);
        rchk(ADDR_MODULE_DISABLE, 16'h0001);
        repeat (4)
        begin
            w = 16'($urandom) & 16'h37ec;
            wr(ADDR_CONTROL_ONE, w);
            rchk(ADDR_CONTROL_ONE, w);
        end
        w = 16'($urandom);
        port_pins_i <= 16'($urandom);
        wr(ADDR_PIN_CONFIG, w);
        rchk(ADDR_PORT_VALUE, port_pins_i & w);
        `CHK(pin_digital_o, w)
        `CHK(digital2, 16'hffff)
        wr(ADDR_CONTROL_ONE, 16'h00e6);
        wait_req(40, got);
        `CHK(got, 1'b0)
        // four-channel scatter order, size 4 per channel
        wr(ADDR_IRQ_MASK, 16'h0001);
        wr(ADDR_DMA_CONFIG, 16'h0002);
        raw = 12'($urandom);
        wr(ADDR_CONTROL_ONE, 16'h80e6);
        for (int k = 0; k < 5; k++)
        begin
            wait_req(100, got);
            `CHK(got, 1'b1)
            `CHK(dma_o.addr, 8'(((k % 4) << 2) | (k / 4)))
            `CHK(dma_o.data, fmt(raw, 1'b0, 1'b0))
            `CHK(sample2, 1'b0)
        end
        `CHK(irq_o, 1'b1)
        wr(ADDR_CONTROL_ONE, 16'h0001);
        rchk(ADDR_CONTROL_ONE, 16'h0001);
        wr(ADDR_IRQ_STATUS, 16'h0003);
        rchk(ADDR_IRQ_STATUS, 16'h0000);
        // every trigger source, every resolution and format
        wr(ADDR_IRQ_MASK, 16'h0000);
        for (int i = 0; i < 5; i++)
        begin
            raw = 12'($urandom);
            c = 16'h9002 | (16'(i[0]) << 10) | (16'(i[1]) << 8);
            c = c | 16'(trig[i] << 5);
            wr(ADDR_CONTROL_ONE, c);
            repeat (4) @(posedge clock_i);
            if (bad[i] != 0)
            begin
                fire(bad[i]);
                wait_req(20, got);
                `CHK(got, 1'b0)
            end
            if (good[i] == 4)
                wr(ADDR_CONTROL_ONE, c & 16'hfffd);
            else
                fire(good[i]);
            wait_req(100, got);
            `CHK(got, 1'b1)
            `CHK(dma_o.data, fmt(raw, i[0], i[1]))
            `CHK(dma_o.addr, 8'(5 + i))
            if (i == 0)
                `CHK(run_len, AUTO_SAMPLE_CYCLES)
            wr(ADDR_CONTROL_ONE, 16'h0001);
        end
        rchk(ADDR_IRQ_STATUS, 16'h0001);
        `CHK(irq_o, 1'b0)
        wr(ADDR_IRQ_STATUS, 16'h0003);
        // reserved sources ignore every event
        for (int r = 3; r < 7; r += 3)
        begin
            wr(ADDR_CONTROL_ONE, 16'h8002 | 16'(r << 5));
            for (int f = 1; f < 4; f++)
                fire(f);
            wait_req(30, got);
            `CHK(got, 1'b0)
            wr(ADDR_CONTROL_ONE, 16'h0001);
        end
        // idle mode halts only with idle_stop set
        for (int s = 0; s < 2; s++)
        begin
            idle_mode_i <= 1'b1;
            wr(ADDR_CONTROL_ONE, 16'h80e6 | 16'(s << 13));
            wait_req(60, got);
            `CHK(got, s == 0)
            idle_mode_i <= 1'b0;
            wait_req(100, got);
            `CHK(got, 1'b1)
            wr(ADDR_CONTROL_ONE, 16'h0001);
        end
        give_verdict();
    end

    initial
    begin
        repeat (20000) @(posedge clock_i);
        error_cnt++;
        give_verdict();
    end
endmodule // acs_top_test
`default_nettype wire
